// [common/serial_rx_pkg.sv]
/*
 * Constants for the asynchronous serial receiver: register offsets, field
 * positions, the control reset value, oversampling figures and the frame state codes.
 * Assumes a byte-wide register port with a two-bit word address.
 */
package serial_rx_pkg;
    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;

    // register word offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL = 2'h0;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 2'h1;
    localparam logic [ADDR_W-1:0] OFS_DATA = 2'h2;
    localparam logic [ADDR_W-1:0] OFS_EXTRA = 2'h3;

    // control register fields
    localparam int CTL_CHAR9 = 0;
    localparam int CTL_WAKE_ADDR = 1;
    localparam int CTL_IDLE_AFTER_STOP = 2;
    localparam int CTL_PARITY_EN = 3;
    localparam int CTL_PARITY_ODD = 4;
    localparam int CTL_STANDBY = 5;
    localparam int CTL_RX_IRQ_EN = 6;
    localparam int CTL_IDLE_IRQ_EN = 7;
    localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;

    // status register fields
    localparam int STA_RX_FULL = 0;
    localparam int STA_IDLE = 1;
    localparam int STA_OVERRUN = 2;
    localparam int STA_NOISE = 3;
    localparam int STA_FRAMING = 4;
    localparam int STA_PARITY = 5;
    localparam int STA_BREAK = 6;
    localparam int STA_BUSY = 7;

    // oversampling: ticks per bit, sample points, data bit counts and idle lengths in bits
    localparam logic [4:0] TICKS_PER_BIT = 5'h10;
    localparam logic [4:0] TICK_FIRST = 5'h01;
    localparam logic [4:0] TICK_V1 = 5'h03;
    localparam logic [4:0] TICK_V2 = 5'h05;
    localparam logic [4:0] TICK_V3 = 5'h07;
    localparam logic [4:0] TICK_M1 = 5'h08;
    localparam logic [4:0] TICK_M2 = 5'h09;
    localparam logic [4:0] TICK_M3 = 5'h0a;
    localparam logic [4:0] TICK_EARLY = 5'h0c;
    localparam logic [3:0] BITS_8 = 4'h8;
    localparam logic [3:0] BITS_9 = 4'h9;
    localparam logic [7:0] IDLE_BITS_8 = 8'h0a;
    localparam logic [7:0] IDLE_BITS_9 = 8'h0b;

    typedef enum logic [3:0] {
        ST_HUNT = 4'b0001,
        ST_START = 4'b0010,
        ST_DATA = 4'b0100,
        ST_STOP = 4'b1000
    } frame_state_e;
endpackage : serial_rx_pkg

// [hw/async_serial_receiver.sv]
/*
 * Receive half of an asynchronous serial port: start-bit hunt and check,
 * majority-vote bit recovery at 16 ticks per bit, receive buffer, error flags,
 * standby with address-mark or idle-line wakeup, and one interrupt request.
 * Assumes rx_sample_tick is a one-cycle strobe at sixteen times the baud rate
 * and that all inputs are synchronous to clock.
 */
// Notes on behaviour
// - 8 or 9 data bits; extra bit holds bit8/bit7
// - complete character loads buffer, sets receive-full
// - receive-full with enable raises interrupt
// - line sampled on sixteen-times-baud tick
// - resync after start bit and 1-to-0 change
// - start is 0 after three 1s; count 16
// - start checked at ticks 3,5,7; two ones abort
// - start patterns 001/010/100 set noise
// - data bit is majority of ticks 8-10
// - start ones at ticks 8-10 only flag noise
// - stop majority 0 is framing error; mixed noise
// - framing error set with receive-full, breaks included
// - realign on valid falling edges inside character
// - standby suppresses all receiver interrupts
// - address mark wakes and sets receive-full
// - waking idle sets neither idle nor full
// - idle count starts after start or stop
// - idle-wake standby may wake at once
// - idle after 10/11 ones; interrupt when enabled
// - overrun keeps old character, drops new
// - break clears buffer and extra bit, sets break
// - parity checked odd or even when enabled
`timescale 1ns/10ps
module async_serial_receiver
    import serial_rx_pkg::*;
(
    input wire logic clock, // module clock
    input wire logic rst_n, // asynchronous reset, active low
    input wire logic rx_sample_tick, // strobe at 16x baud
    input wire logic rx_serial_pin, // receive line
    input wire logic [ADDR_W-1:0] reg_addr, // register word address
    input wire logic [DATA_W-1:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [DATA_W-1:0] reg_rdata, // read data, cycle after strobe
    output logic rx_irq // receiver interrupt request
);
    function automatic logic majority(input logic [2:0] s);
        return (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
    endfunction : majority

    function automatic logic mixed(input logic [2:0] s);
        return (s != 3'h0) && (s != 3'h7);
    endfunction : mixed

    frame_state_e state_q;
    logic [4:0] tick_cnt_q;
    logic [3:0] bit_idx_q;
    logic [8:0] shift_q;
    logic [2:0] hist_q;
    logic [2:0] trio_q;
    logic [1:0] verify_q;
    logic noise_acc_q;
    logic prev_bit_q;
    logic last_sample_q;
    logic [7:0] idle_cnt_q;
    logic idle_armed_q;
    logic [DATA_W-1:0] ctrl_q;
    logic [7:0] buffer_q;
    logic extra_q;
    logic full_q, idle_q, overrun_q, noise_q, framing_q, parity_q, break_q;

    logic smp;
    logic [2:0] trio_now;
    logic verify_fail, edge_fall, early_edge, late_edge, bit_end, done;
    logic [3:0] nbits;
    logic [7:0] idle_limit;
    logic [8:0] data_now;
    logic stop_bit, char_noise, char_break, char_parity, msb;
    logic standby, accept, idle_hit, rd_data, wr_ctrl;

    assign smp = rx_serial_pin;
    assign nbits = ctrl_q[CTL_CHAR9] ? BITS_9 : BITS_8;
    assign trio_now = {trio_q[1:0], smp};
    assign verify_fail = majority({verify_q, smp});
    assign edge_fall = rx_sample_tick && last_sample_q && !smp && prev_bit_q;
    // a fall after the sample window belongs to the next bit, one before it is a late bit
    assign early_edge = edge_fall && (tick_cnt_q >= TICK_EARLY);
    assign late_edge = edge_fall && (tick_cnt_q > TICK_FIRST) && (tick_cnt_q <= TICK_V3);
    assign bit_end = (rx_sample_tick && tick_cnt_q == TICKS_PER_BIT) || early_edge;
    assign done = rx_sample_tick && state_q == ST_STOP && tick_cnt_q == TICK_M3;

    // stop-bit evaluation and character summary
    assign stop_bit = majority(trio_now);
    // character aligned to bit 0; in 8-bit mode the low shift bit is stale
    assign data_now = ctrl_q[CTL_CHAR9] ? shift_q : {1'b0, shift_q[8:1]};
    assign msb = shift_q[8];
    assign char_noise = noise_acc_q | mixed(trio_now);
    assign char_break = (data_now == 9'h000) && !stop_bit;
    assign char_parity = ctrl_q[CTL_PARITY_EN] &&
        (((ctrl_q[CTL_CHAR9] ? ^shift_q : ^shift_q[8:1])) != ctrl_q[CTL_PARITY_ODD]);
    assign standby = ctrl_q[CTL_STANDBY];
    // in idle-wake standby no character is taken; in address standby only a marked one
    assign accept = done && (!standby || (ctrl_q[CTL_WAKE_ADDR] && msb));

    assign idle_limit = ctrl_q[CTL_CHAR9] ? 8'(IDLE_BITS_9 * TICKS_PER_BIT) : 8'(IDLE_BITS_8 * TICKS_PER_BIT);
    assign idle_hit = rx_sample_tick && smp && idle_armed_q && (idle_cnt_q == idle_limit - 8'h01);
    assign rd_data = reg_rd && reg_addr == OFS_DATA;
    assign wr_ctrl = reg_wr && reg_addr == OFS_CTRL;

    // frame sequencer: hunt, start check, data bits, stop bit
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_HUNT;
            tick_cnt_q <= TICK_FIRST;
            bit_idx_q <= 4'h0;
            shift_q <= 9'h000;
            hist_q <= 3'h0;
            trio_q <= 3'h0;
            verify_q <= 2'h0;
            noise_acc_q <= 1'b0;
            prev_bit_q <= 1'b0;
            last_sample_q <= 1'b1;
        end else if (rx_sample_tick) begin
            hist_q <= {hist_q[1:0], smp};
            last_sample_q <= smp;
            tick_cnt_q <= bit_end || late_edge ? TICK_FIRST : tick_cnt_q + 5'h01;
            if (tick_cnt_q == TICK_V1) begin
                verify_q[1] <= smp;
            end
            if (tick_cnt_q == TICK_V2) begin
                verify_q[0] <= smp;
            end
            if (tick_cnt_q == TICK_M1 || tick_cnt_q == TICK_M2) begin
                trio_q <= trio_now;
            end
            case (state_q)
                ST_HUNT: begin
                    prev_bit_q <= 1'b0;
                    if (hist_q == 3'h7 && !smp) begin
                        state_q <= ST_START;
                        tick_cnt_q <= TICK_FIRST + 5'h01; // this tick was the first
                        noise_acc_q <= 1'b0;
                    end else begin
                        tick_cnt_q <= TICK_FIRST;
                    end
                end
                ST_START: begin
                    if (tick_cnt_q == TICK_V3) begin
                        if (verify_fail) begin
                            state_q <= ST_HUNT;
                            tick_cnt_q <= TICK_FIRST;
                        end else if (verify_q != 2'h0 || smp) begin
                            noise_acc_q <= 1'b1;
                        end
                    end
                    if (tick_cnt_q == TICK_M3 && trio_now != 3'h0) begin
                        noise_acc_q <= 1'b1;
                    end
                    if (tick_cnt_q == TICKS_PER_BIT) begin
                        state_q <= ST_DATA;
                        bit_idx_q <= 4'h0;
                    end
                end
                ST_DATA, ST_STOP: begin
                    if (tick_cnt_q == TICK_M3) begin
                        prev_bit_q <= majority(trio_now);
                        if (state_q == ST_DATA) begin
                            shift_q <= {majority(trio_now), shift_q[8:1]};
                            if (mixed(trio_now)) begin
                                noise_acc_q <= 1'b1;
                            end
                        end else begin
                            state_q <= ST_HUNT;
                        end
                    end
                    if (bit_end && state_q == ST_DATA) begin
                        bit_idx_q <= bit_idx_q + 4'h1;
                        if (bit_idx_q == nbits - 4'h1) begin
                            state_q <= ST_STOP;
                        end
                    end
                end
                default: begin
                    state_q <= ST_HUNT;
                end
            endcase
        end
    end

    // idle-line counter in ticks of continuous mark
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            idle_cnt_q <= 8'h00;
            idle_armed_q <= 1'b0;
        end else begin
            if (rx_sample_tick) begin
                if (!smp || (ctrl_q[CTL_IDLE_AFTER_STOP] && state_q != ST_HUNT)) begin
                    idle_cnt_q <= 8'h00;
                end else if (idle_cnt_q != idle_limit) begin
                    idle_cnt_q <= idle_cnt_q + 8'h01;
                end
            end
            // rearmed by a character or by entering standby, so one idle per gap
            if (state_q == ST_START || (wr_ctrl && reg_wdata[CTL_STANDBY])) begin
                idle_armed_q <= 1'b1;
            end else if (idle_hit) begin
                idle_armed_q <= 1'b0;
            end
        end
    end

    // control register; software set of standby wins over a wakeup in the same cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= reg_wdata;
        end else if (standby && ctrl_q[CTL_WAKE_ADDR] && accept) begin
            ctrl_q[CTL_STANDBY] <= 1'b0;
        end else if (standby && !ctrl_q[CTL_WAKE_ADDR] && idle_hit) begin
            ctrl_q[CTL_STANDBY] <= 1'b0;
        end
    end

    // receive buffer and flags; a set in the clearing cycle wins
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            buffer_q <= 8'h00;
            extra_q <= 1'b0;
            full_q <= 1'b0;
            idle_q <= 1'b0;
            overrun_q <= 1'b0;
            noise_q <= 1'b0;
            framing_q <= 1'b0;
            parity_q <= 1'b0;
            break_q <= 1'b0;
        end else begin
            if (rd_data) begin
                full_q <= 1'b0;
                idle_q <= 1'b0;
                overrun_q <= 1'b0;
                noise_q <= 1'b0;
                framing_q <= 1'b0;
                parity_q <= 1'b0;
                break_q <= 1'b0;
            end
            if (accept && full_q && !rd_data) begin
                overrun_q <= 1'b1;
            end else if (accept) begin
                buffer_q <= char_break ? 8'h00 : data_now[7:0];
                extra_q <= char_break ? 1'b0 : msb;
                full_q <= 1'b1;
                noise_q <= char_noise;
                framing_q <= !stop_bit;
                parity_q <= char_parity;
                break_q <= char_break;
            end
            if (idle_hit && !standby) begin
                idle_q <= 1'b1;
            end
        end
    end

    // register read port and interrupt request
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
            rx_irq <= 1'b0;
        end else begin
            rx_irq <= !standby && ((full_q && ctrl_q[CTL_RX_IRQ_EN]) ||
                (idle_q && ctrl_q[CTL_IDLE_IRQ_EN]));
            reg_rdata <= 8'h00;
            if (reg_rd) begin
                case (reg_addr)
                    OFS_CTRL: reg_rdata <= ctrl_q;
                    OFS_STATUS: reg_rdata <= {state_q != ST_HUNT, break_q, parity_q, framing_q,
                        noise_q, overrun_q, idle_q, full_q};
                    OFS_DATA: reg_rdata <= buffer_q;
                    OFS_EXTRA: reg_rdata <= {7'h00, extra_q};
                    default: reg_rdata <= 8'h00;
                endcase
            end
        end
    end
endmodule : async_serial_receiver

// [dv/async_serial_receiver_monitor.sv]
/*
 * Port checker for the serial receiver: register read timing, interrupt
 * gating and flag consistency. Assumes it is bound to the receiver top.
 */
`timescale 1ns/10ps
module async_serial_receiver_monitor
    import serial_rx_pkg::*;
(
    input wire logic clock, // module clock
    input wire logic rst_n, // async reset, active low
    input wire logic rx_sample_tick, // 16x strobe
    input wire logic rx_serial_pin, // receive line
    input wire logic [ADDR_W-1:0] reg_addr, // word address
    input wire logic [DATA_W-1:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [DATA_W-1:0] reg_rdata, // read data
    input wire logic rx_irq // interrupt request
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_sta_rd; reg_rd && reg_addr == OFS_STATUS; endsequence
    sequence s_ctl_wr; reg_wr && reg_addr == OFS_CTRL; endsequence
    sequence s_ctl_rd; reg_rd && reg_addr == OFS_CTRL; endsequence
    property p_rdata_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
    property p_standby_quiet; s_ctl_wr ##0 reg_wdata[CTL_STANDBY] |=> ##1 !rx_irq; endproperty
    a_standby_quiet: assert property (p_standby_quiet) else $error("irq in standby");
    property p_irq_off; s_ctl_wr ##0 reg_wdata[7:6] == 2'b00 |=> ##1 !rx_irq; endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
    property p_fe_full; s_sta_rd |=> !reg_rdata[STA_FRAMING] || reg_rdata[STA_RX_FULL]; endproperty
    a_fe_full: assert property (p_fe_full) else $error("framing without full");
    property p_break_fe; s_sta_rd |=> !reg_rdata[STA_BREAK] || reg_rdata[STA_FRAMING]; endproperty
    a_break_fe: assert property (p_break_fe) else $error("break without framing");
    property p_noise_full; s_sta_rd |=> !reg_rdata[STA_NOISE] || reg_rdata[STA_RX_FULL]; endproperty
    a_noise_full: assert property (p_noise_full) else $error("noise without full");
    property p_ovr_full; s_sta_rd |=> !reg_rdata[STA_OVERRUN] || reg_rdata[STA_RX_FULL]; endproperty
    a_ovr_full: assert property (p_ovr_full) else $error("overrun without full");
    property p_ctrl_back;
        s_ctl_wr ##1 s_ctl_rd |=> (reg_rdata & 8'hdf) == ($past(reg_wdata, 2) & 8'hdf);
    endproperty
    a_ctrl_back: assert property (p_ctrl_back) else $error("control readback wrong");
endmodule : async_serial_receiver_monitor

bind async_serial_receiver async_serial_receiver_monitor mon (.clock(clock), .rst_n(rst_n),
    .rx_sample_tick(rx_sample_tick), .rx_serial_pin(rx_serial_pin), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_irq(rx_irq));

// [dv/serial_tx_model.sv]
/*
 * Remote transmitter: shifts frames LSB first, 16 ticks a bit, with an
 * optional one-tick glitch. Assumes the tick strobe the receiver uses.
 */
`timescale 1ns/10ps
module serial_tx_model (
    input wire logic clock, // module clock
    input wire logic tick, // 16x strobe
    output logic line // receive line, idles high
);
    initial line = 1'b1;
    task automatic wait_ticks(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            while (!tick) @(posedge clock);
        end
    endtask : wait_ticks
    task automatic send(input logic [10:0] frame, input int n, input int gbit, input int gtick);
        wait_ticks(16); // idle lead gives the hunter its three ones
        for (int b = 0; b < n; b++) begin
            line <= frame[b];
            if (b == gbit) begin
                wait_ticks(gtick - 1);
                line <= !frame[b];
                wait_ticks(1);
                line <= frame[b];
                wait_ticks(16 - gtick);
            end else begin
                wait_ticks(16);
            end
        end
        line <= 1'b1;
        wait_ticks(4);
    endtask : send
endmodule : serial_tx_model

// [dv/async_serial_receiver_tb_top.sv]
/*
 * Self-checking bench for the serial receiver: register tasks, frame table,
 * overrun, standby wakeups and idle detection. Assumes the transmitter model.
 */
`timescale 1ns/10ps
module async_serial_receiver_tb_top
    import serial_rx_pkg::*;
;
    typedef struct {logic [7:0] ctl; logic [8:0] d; logic nine; logic stp; int gb; int gt;
        logic [7:0] sta; logic [7:0] dat; logic ext;} rx_case_s;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic rx_sample_tick = 1'b0;
    logic rx_serial_pin;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic rx_irq;
    int fails = 0;
    int checks_done = 0;
    rx_case_s cases [10] = '{
        '{8'h40, 9'h0a5, 0, 1, -1, 0, 8'h01, 8'ha5, 1}, '{8'h40, 9'h03c, 0, 1, 3, 9, 8'h09, 8'h3c, 0},
        '{8'h40, 9'h03c, 0, 1, 0, 3, 8'h09, 8'h3c, 0}, '{8'h40, 9'h03c, 0, 1, 0, 9, 8'h09, 8'h3c, 0},
        '{8'h40, 9'h03c, 0, 1, 9, 9, 8'h09, 8'h3c, 0}, '{8'h40, 9'h03c, 0, 0, -1, 0, 8'h11, 8'h3c, 0},
        '{8'h40, 9'h000, 0, 0, -1, 0, 8'h51, 8'h00, 0}, '{8'h41, 9'h0f3, 1, 1, -1, 0, 8'h01, 8'hf3, 0},
        '{8'h58, 9'h001, 0, 1, -1, 0, 8'h01, 8'h01, 0},
        '{8'h48, 9'h001, 0, 1, -1, 0, 8'h21, 8'h01, 0}};

    async_serial_receiver DUT (.clock(clock), .rst_n(rst_n), .rx_sample_tick(rx_sample_tick),
        .rx_serial_pin(rx_serial_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_irq(rx_irq));
    serial_tx_model tx (.clock(clock), .tick(rx_sample_tick), .line(rx_serial_pin));

    initial forever #2 clock = ~clock;
    always @(posedge clock) rx_sample_tick <= !rx_sample_tick;

    function automatic logic [10:0] frm(input logic [8:0] d, input logic nine, input logic stp);
        return nine ? {stp, d, 1'b0} : {1'b1, stp, d[7:0], 1'b0};
    endfunction : frm
    task automatic results();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input string what);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
        check(what, exp, reg_rdata);
    endtask : rd
    task automatic wait_irq(input int lim);
        int n = 0;
        while (rx_irq !== 1'b1 && n < lim) begin
            @(posedge clock);
            n++;
        end
        check("rx_irq", 8'h01, {7'h00, rx_irq});
        if (n == lim) results();
    endtask : wait_irq

    initial begin
        repeat (60000) @(posedge clock);
        fails++;
        results();
    end

    initial begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rd(OFS_CTRL, 8'h00, "ctrl reset");
        rd(OFS_STATUS, 8'h00, "status reset");
        // rows by frame kind: clean, noisy samples (four rows), bad stop, break, nine bits, parity (two rows)
        foreach (cases[i]) begin
            wr(OFS_CTRL, cases[i].ctl);
            rd(OFS_CTRL, cases[i].ctl, "ctrl");
            tx.send(frm(cases[i].d, cases[i].nine, cases[i].stp), cases[i].nine ? 11 : 10, cases[i].gb, cases[i].gt);
            wait_irq(100);
            rd(OFS_STATUS, cases[i].sta, "status");
            rd(OFS_EXTRA, {7'h00, cases[i].ext}, "extra bit");
            rd(OFS_DATA, cases[i].dat, "data");
            rd(OFS_STATUS, 8'h00, "status cleared");
        end
        // second character lands on an unread buffer
        tx.send(frm(9'h011, 0, 1), 10, -1, 0);
        tx.send(frm(9'h022, 0, 1), 10, -1, 0);
        rd(OFS_STATUS, 8'h05, "overrun status");
        rd(OFS_DATA, 8'h11, "kept data");
        wr(OFS_CTRL, 8'h62);
        tx.send(frm(9'h012, 0, 1), 10, -1, 0);
        check("rx_irq", 8'h00, {7'h00, rx_irq});
        rd(OFS_STATUS, 8'h00, "standby status");
        tx.send(frm(9'h081, 0, 1), 10, -1, 0);
        rd(OFS_CTRL, 8'h42, "ctrl woken");
        rd(OFS_STATUS, 8'h01, "mark status");
        wait_irq(10);
        wr(OFS_CTRL, 8'h62);
        repeat (2) @(posedge clock);
        check("rx_irq", 8'h00, {7'h00, rx_irq});
        rd(OFS_DATA, 8'h81, "mark data");
        // idle wake needs 160 ticks of ones, two clocks a tick
        wr(OFS_CTRL, 8'ha0);
        repeat (400) @(posedge clock);
        rd(OFS_CTRL, 8'h80, "ctrl idle woken");
        rd(OFS_STATUS, 8'h00, "idle wake status");
        tx.send(frm(9'h0ff, 0, 1), 10, -1, 0);
        wait_irq(1000);
        rd(OFS_STATUS, 8'h03, "idle status");
        // count after stop: no idle within the first bit times of the gap
        rd(OFS_DATA, 8'hff, "idle data");
        wr(OFS_CTRL, 8'h84);
        tx.send(frm(9'h0ff, 0, 1), 10, -1, 0);
        repeat (100) @(posedge clock);
        check("early idle irq", 8'h00, {7'h00, rx_irq});
        wait_irq(1000);
        rd(OFS_STATUS, 8'h03, "idle after stop");
        results();
    end
endmodule : async_serial_receiver_tb_top
